// ===== hw/watchdog_interval_timer_ctrl.v
// Purpose: watchdog / interval timer control and status
// Assumes: 16-bit write data with key in upper byte; 8-bit reads
// Notes: register port: REG_ADDR 0 control(rd)/counter+control(wr), 1 counter(rd),
//        2 reset-control write, 3 reset-control read
`timescale 1ns/10ps
`default_nettype none
`include "wdt_regs.vh"
module watchdog_interval_timer_ctrl (
  input wire CLOCK,
  input wire RESET,
  input wire [1:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [15:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  output reg INTERVAL_IRQ,
  output reg OVERFLOW_OUT_N,
  output reg INTERNAL_RESET
);
  // timer state
  reg [7:0] watchdog_counter;
  reg interval_overflow_flag;
  reg timer_mode_select;
  reg timer_run_enable;
  reg [2:0] clock_select;
  reg watchdog_overflow_flag;
  reg chip_reset_enable;
  reg spare_bit;
  reg ovf_seen;
  reg watchdog_overflow_flag_seen;
  wire tick;
  wire ovf_pulse;
  wire ovf_busy;
  wire rst_busy;
  wire [9:0] ovf_len;
  wire key_count;
  wire key_ctrl;
  wire wr_count;
  wire wr_ctrl;
  wire wr_chip_reset_enable;
  wire wr_watchdog_overflow_flag;
  wire rd_ctrl;
  wire rd_rstc;
  wire wrap;
  wire wd_wrap;
  wire iv_wrap;
  wire [7:0] ctrl_view;
  wire [7:0] rstc_view;

  // count tick from the prescaler
  wdt_prescaler prescale (
    .clk(CLOCK),
    .rst(RESET),
    .run(timer_run_enable),
    .sel(clock_select),
    .tick(tick)
  );

  // overflow output length depends on chip reset enable
  assign ovf_len = chip_reset_enable ? {1'b0, `OVF_OUT_LONG} : {1'b0, `OVF_OUT_SHORT};

  wdt_pulse ovf_stretch (
    .clk(CLOCK),
    .rst(RESET),
    .start(wd_wrap),
    .len(ovf_len),
    .active(ovf_pulse)
  ); // see RQ17

  wdt_pulse reset_stretch (
    .clk(CLOCK),
    .rst(RESET),
    .start(wd_wrap && chip_reset_enable),
    .len(`INT_RESET_LEN),
    .active(rst_busy)
  ); // see RQ14 see RQ17

  // writes are locked while the overflow output is low
  assign ovf_busy = ovf_pulse;
  assign key_count = (REG_WDATA[15:8] == `KEY_COUNT);
  assign key_ctrl = (REG_WDATA[15:8] == `KEY_CTRL);
  assign wr_count = REG_WR && !ovf_busy && (REG_ADDR == `ADDR_CTRL) && key_count; // see RQ18
  assign wr_ctrl = REG_WR && !ovf_busy && (REG_ADDR == `ADDR_CTRL) && key_ctrl; // see RQ18
  assign wr_chip_reset_enable = REG_WR && !ovf_busy && (REG_ADDR == `ADDR_RSTC_WR) && key_count; // see RQ18
  assign wr_watchdog_overflow_flag = REG_WR && !ovf_busy && (REG_ADDR == `ADDR_RSTC_WR) && key_ctrl
                   && (REG_WDATA[7:0] == 8'h00); // see RQ18
  assign rd_ctrl = REG_RD && (REG_ADDR == `ADDR_CTRL);
  // watchdog flag reads are not recognised during the overflow output
  assign rd_rstc = REG_RD && !ovf_busy && (REG_ADDR == `ADDR_RSTC);

  // overflow on an increment from the top value
  assign wrap = tick && !wr_count && (watchdog_counter == `COUNT_TOP); // see RQ1 see RQ20
  assign wd_wrap = wrap && timer_mode_select; // see RQ6 see RQ11
  assign iv_wrap = wrap && !timer_mode_select; // see RQ5

  // read views with reserved bits held at one
  assign ctrl_view = {interval_overflow_flag, timer_mode_select, timer_run_enable,
                      2'b00, clock_select} | `CTRL_FIXED; // see RQ9
  assign rstc_view = {watchdog_overflow_flag, chip_reset_enable, spare_bit, 5'h00}
                     | `RSTC_FIXED; // see RQ9 see RQ15

  // counter: write beats increment, run clear forces zero
  always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      watchdog_counter <= 8'h00;
    end else if (wd_wrap || rst_busy) begin
      watchdog_counter <= 8'h00; // see RQ13
    end else if (!timer_run_enable || (wr_ctrl && !REG_WDATA[`BIT_RUN])) begin
      watchdog_counter <= 8'h00; // see RQ7 see RQ19
    end else if (wr_count) begin
      watchdog_counter <= REG_WDATA[7:0]; // see RQ20
    end else if (tick) begin
      watchdog_counter <= watchdog_counter + 8'h01; // see RQ19
    end
  end

  // control/status: cleared by any watchdog overflow, internal reset or not
  always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      interval_overflow_flag <= 1'b0;
      timer_mode_select <= 1'b0;
      timer_run_enable <= 1'b0;
      clock_select <= 3'h0;
      ovf_seen <= 1'b0;
    end else if (wd_wrap || rst_busy) begin
      interval_overflow_flag <= 1'b0; // see RQ2 see RQ13
      timer_mode_select <= 1'b0;
      timer_run_enable <= 1'b0;
      clock_select <= 3'h0;
      ovf_seen <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        timer_mode_select <= REG_WDATA[`BIT_MODE];
        timer_run_enable <= REG_WDATA[`BIT_RUN]; // see RQ7
        clock_select <= REG_WDATA[2:0]; // see RQ8
      end
      // set beats clear; zero write only after a read that saw the flag set
      if (iv_wrap) begin
        interval_overflow_flag <= 1'b1; // see RQ1
      end else if (wr_ctrl && ovf_seen && !REG_WDATA[`BIT_FLAG]) begin
        interval_overflow_flag <= 1'b0; // see RQ3 see RQ16
      end
      if (rd_ctrl && interval_overflow_flag) begin
        ovf_seen <= 1'b1; // see RQ3
      end else if (wr_ctrl) begin
        ovf_seen <= 1'b0;
      end
    end
  end

  // reset control: only the external reset initialises it
  always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      watchdog_overflow_flag <= 1'b0; // see RQ10
      chip_reset_enable <= 1'b0;
      spare_bit <= 1'b0;
      watchdog_overflow_flag_seen <= 1'b0;
    end else begin
      if (wr_chip_reset_enable) begin
        chip_reset_enable <= REG_WDATA[`BIT_CHIP_RESET_ENABLE];
        spare_bit <= REG_WDATA[`BIT_SPARE]; // see RQ15
      end
      if (wd_wrap) begin
        watchdog_overflow_flag <= 1'b1; // see RQ11
      end else if (wr_watchdog_overflow_flag && watchdog_overflow_flag_seen) begin
        watchdog_overflow_flag <= 1'b0; // see RQ12 see RQ16
      end
      if (rd_rstc && watchdog_overflow_flag) begin
        watchdog_overflow_flag_seen <= 1'b1; // see RQ12
      end else if (wr_watchdog_overflow_flag) begin
        watchdog_overflow_flag_seen <= 1'b0;
      end
    end
  end

  // registered outputs and read data
  always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
      INTERVAL_IRQ <= 1'b0;
      OVERFLOW_OUT_N <= 1'b1;
      INTERNAL_RESET <= 1'b0;
    end else begin
      INTERVAL_IRQ <= interval_overflow_flag; // see RQ5
      OVERFLOW_OUT_N <= !ovf_pulse; // see RQ6
      INTERNAL_RESET <= rst_busy; // see RQ14
      if (REG_RD) begin
        case (REG_ADDR)
          `ADDR_CTRL: REG_RDATA <= ctrl_view;
          `ADDR_COUNT: REG_RDATA <= watchdog_counter;
          `ADDR_RSTC: REG_RDATA <= rstc_view;
          default: REG_RDATA <= 8'h00;
        endcase
      end
    end
  end
endmodule // watchdog_interval_timer_ctrl
`default_nettype wire

// ===== hw/wdt_prescaler.v
// Purpose: divider, held at zero while run is low, giving one-cycle count ticks
// Assumes: run low holds the divider at zero so the first tick is a full period
// Notes: tick on the carry of the selected stage
`timescale 1ns/10ps
`default_nettype none
`include "wdt_regs.vh"
module wdt_prescaler (
  input wire clk,
  input wire rst,
  input wire run,
  input wire [2:0] sel,
  output wire tick
);
  reg [`PRESCALE_W-1:0] div;
  reg [`PRESCALE_W-1:0] mask;
  // divisor minus one per select code
  always @* begin
    case (sel)
      3'h0: mask = `DIV_MASK_0;
      3'h1: mask = `DIV_MASK_1;
      3'h2: mask = `DIV_MASK_2;
      3'h3: mask = `DIV_MASK_3;
      3'h4: mask = `DIV_MASK_4;
      3'h5: mask = `DIV_MASK_5;
      3'h6: mask = `DIV_MASK_6;
      default: mask = `DIV_MASK_7;
    endcase
  end
  // divider restarts when stopped
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= 17'h00000;
    end else if (!run) begin
      div <= 17'h00000;
    end else begin
      div <= div + 17'h00001;
    end
  end
  assign tick = run && ((div & mask) == mask); // see RQ8 see RQ21
endmodule // wdt_prescaler
`default_nettype wire

// ===== hw/wdt_pulse.v
// Purpose: fixed-length pulse stretcher
// Assumes: start is a one-cycle pulse; a start during a pulse is ignored
// Notes: active output is high
`timescale 1ns/10ps
`default_nettype none
module wdt_pulse (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [9:0] len,
  output reg active
);
  reg [9:0] left;
  // count down the requested length
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      left <= 10'h000;
      active <= 1'b0;
    end else if (start && !active) begin
      left <= len - 10'h001;
      active <= 1'b1;
    end else if (active) begin
      left <= left - 10'h001;
      active <= (left != 10'h000);
    end
  end
endmodule // wdt_pulse
`default_nettype wire

// ===== hw/wdt_regs.vh
// Purpose: constants for the watchdog/interval timer block
// Assumes: 25 MHz peripheral clock, word-wide register port with key byte
// Notes:
// Behaviour
// RQ1: interval mode sets interval overflow flag when counter wraps FF to 00.
// RQ2: internal chip reset from watchdog overflow clears the interval overflow flag.
// RQ3: interval flag clears only after a read seeing it set, then writing zero.
// RQ4: software should read the interval flag back after clearing it.
// RQ5: mode bit 6 zero selects interval timer, overflow requests interval interrupt.
// RQ6: mode bit one selects watchdog, overflow asserts active-low overflow output.
// RQ7: run enable bit 5 starts counting; clearing stops and zeroes the counter.
// RQ8: clock select codes 0-7 pick divide 2,64,128,512,2048,8192,32768,131072.
// RQ9: reserved control bits 4,3 and reset control bits 4..0 read one.
// RQ10: reset control resets to 1F on external pin, kept on internal reset.
// RQ11: watchdog flag sets on wrap in watchdog mode only.
// RQ12: watchdog flag clears only after a read seeing it set, then zero write.
// RQ13: chip reset disabled: overflow still resets counter and control register.
// RQ14: chip reset enabled: watchdog overflow triggers whole-chip internal reset.
// RQ15: reset control bit 5 is plain storage, resets zero, no effect.
// RQ16: writing one to either overflow flag has no effect.
// RQ17: overflow output lasts 133 or 130 states; internal reset lasts 519.
// RQ18: writes need key byte 5A (counter, reset enable) or A5 (control, flag clear).
// RQ19: counter is 8-bit read/write up-counter, zeroed when run enable clears.
// RQ20: counter write in the same cycle as an increment wins.
// RQ21: free-running prescaler yields one single-cycle tick per divided period. The divider here is held at zero while run is low.
`ifndef WDT_REGS_VH
`define WDT_REGS_VH
`define ADDR_CTRL 2'h0
`define ADDR_COUNT 2'h1
`define ADDR_RSTC_WR 2'h2
`define ADDR_RSTC 2'h3
`define KEY_COUNT 8'h5A
`define KEY_CTRL 8'hA5
`define BIT_FLAG 7
`define BIT_MODE 6
`define BIT_RUN 5
`define BIT_CHIP_RESET_ENABLE 6
`define BIT_SPARE 5
`define CTRL_FIXED 8'h18
`define RSTC_FIXED 8'h1F
`define OVF_OUT_LONG 9'h085
`define OVF_OUT_SHORT 9'h082
`define INT_RESET_LEN 10'h207
`define PRESCALE_W 17
`define COUNT_TOP 8'hFF
`define DIV_MASK_0 17'h00001
`define DIV_MASK_1 17'h0003F
`define DIV_MASK_2 17'h0007F
`define DIV_MASK_3 17'h001FF
`define DIV_MASK_4 17'h007FF
`define DIV_MASK_5 17'h01FFF
`define DIV_MASK_6 17'h07FFF
`define DIV_MASK_7 17'h1FFFF
`endif

// ===== tb/watchdog_interval_timer_ctrl_test.sv
// Purpose: self-checking bench for the watchdog timer
// Assumes: inputs change on the falling edge
// Notes: divide by 2 keeps each overflow near 512 cycles
`timescale 1ns/10ps
`default_nettype none
module watchdog_interval_timer_ctrl_test;
  logic CLOCK = 1'h0;
  logic RESET = 1'h1;
  logic [1:0] REG_ADDR = 2'h0;
  logic REG_WR = 1'h0;
  logic REG_RD = 1'h0;
  logic [15:0] REG_WDATA = 16'h0000;
  wire [7:0] REG_RDATA;
  wire INTERVAL_IRQ, OVERFLOW_OUT_N, INTERNAL_RESET;
  wire [9:0] ovf_len, rst_len;
  integer error_cnt = 0;
  integer n_tests = 0;
  integer k;
  int divs [8] = '{2, 64, 128, 512, 2048, 8192, 32768, 131072};
  // free-running clock
  always #20 CLOCK = ~CLOCK;
  watchdog_interval_timer_ctrl uut (.CLOCK(CLOCK), .RESET(RESET), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .INTERVAL_IRQ(INTERVAL_IRQ), .OVERFLOW_OUT_N(OVERFLOW_OUT_N),
    .INTERNAL_RESET(INTERNAL_RESET));
  wdt_chip_side far (.clk(CLOCK), .ovf_n(OVERFLOW_OUT_N), .irst(INTERNAL_RESET),
    .ovf_len(ovf_len), .rst_len(rst_len));
  task report_and_stop;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // keyed word write, one cycle strobe
  task wr(input logic [1:0] a, input logic [15:0] d);
    @(negedge CLOCK);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'h1;
    @(negedge CLOCK);
    REG_WR = 1'h0;
  endtask
  // data is sampled a full cycle late so either latency reading holds
  task rd(input logic [1:0] a, input logic [7:0] exp);
    @(negedge CLOCK);
    REG_ADDR = a;
    REG_RD = 1'h1;
    @(negedge CLOCK);
    REG_RD = 1'h0;
    @(negedge CLOCK);
    chk("read", {2'h0, exp}, {2'h0, REG_RDATA});
  endtask
  // 0 irq high, 1 overflow low, 2 both pulses over
  task wait_for(input integer which);
    integer i;
    for (i = 0; i < 1200; i = i + 1) begin
      @(negedge CLOCK);
      if ((which == 0 && INTERVAL_IRQ === 1'h1) || (which == 1 && OVERFLOW_OUT_N === 1'h0)
          || (which == 2 && OVERFLOW_OUT_N === 1'h1 && INTERNAL_RESET === 1'h0))
        return;
    end
    error_cnt = error_cnt + 1;
    $display("ERROR wait %0d expected event seen none", which);
    report_and_stop;
  endtask
  initial begin
    repeat (8) @(posedge CLOCK);
    @(negedge CLOCK);
    RESET = 1'h0;
    rd(2'h0, 8'h18);
    rd(2'h3, 8'h1F);
    rd(2'h1, 8'h00);
    wr(2'h0, 16'hA5FF);
    rd(2'h0, 8'h7F);
    wr(2'h0, 16'h5A42);
    rd(2'h1, 8'h42);
    wr(2'h0, 16'hA51F);
    rd(2'h1, 8'h00);
    rd(2'h0, 8'h1F);
    wr(2'h2, 16'h5A3F);
    rd(2'h3, 8'h3F);
    // count for a fixed time per select code 1 to 7; the run bit restarts each one
    for (k = 1; k < 8; k = k + 1) begin
      wr(2'h0, {8'hA5, 5'h04, k[2:0]});
      repeat (1030) @(negedge CLOCK);
      rd(2'h1, 8'(1032 / divs[k]));
      wr(2'h0, 16'hA500);
    end
    wr(2'h0, 16'hA520);
    wait_for(0);
    wr(2'h0, 16'hA520);
    chk("irq", 10'h001, {9'h000, INTERVAL_IRQ});
    rd(2'h0, 8'hB8);
    wr(2'h0, 16'hA500);
    rd(2'h0, 8'h18);
    chk("irq", 10'h000, {9'h000, INTERVAL_IRQ});
    wr(2'h0, 16'hA560);
    wait_for(1);
    wr(2'h2, 16'h5A40);
    wait_for(2);
    rd(2'h0, 8'h18);
    chk("ovf len", 10'h082, ovf_len);
    rd(2'h3, 8'hBF);
    wr(2'h2, 16'hA500);
    rd(2'h3, 8'h3F);
    wr(2'h2, 16'h5A40);
    rd(2'h3, 8'h5F);
    // leave the interval flag set so the watchdog overflow has to clear it
    wr(2'h0, 16'hA520);
    wait_for(0);
    wr(2'h0, 16'hA560);
    wait_for(1);
    chk("int rst", 10'h001, {9'h000, INTERNAL_RESET});
    wait_for(2);
    // the far side latches the reset length one edge after it ends
    @(negedge CLOCK);
    chk("ovf len", 10'h085, ovf_len);
    chk("rst len", 10'h207, rst_len);
    rd(2'h3, 8'hDF);
    rd(2'h0, 8'h18);
    report_and_stop;
  end
endmodule // watchdog_interval_timer_ctrl_test
`default_nettype wire

// ===== tb/wdt_chip_side.sv
// Purpose: chip reset and overflow output side seen from the watchdog pins
// Assumes: a length is latched when its pulse ends
// Notes: a pulse that never ends leaves the last length in place
`timescale 1ns/10ps
`default_nettype none
module wdt_chip_side (
  input wire logic clk,
  input wire logic ovf_n,
  input wire logic irst,
  output logic [9:0] ovf_len,
  output logic [9:0] rst_len
);
  logic [9:0] ovf_run = 10'h000;
  logic [9:0] rst_run = 10'h000;
  // measure each overflow pulse and each reset request
  always @(posedge clk) begin
    ovf_run <= ovf_n ? 10'h000 : ovf_run + 10'h001;
    rst_run <= irst ? rst_run + 10'h001 : 10'h000;
    if (ovf_n && ovf_run != 10'h000)
      ovf_len <= ovf_run;
    if (!irst && rst_run != 10'h000)
      rst_len <= rst_run;
  end
endmodule // wdt_chip_side
`default_nettype wire

// ===== tb/wdt_port_chk_sva.sv
// Purpose: port assertions for the watchdog timer
// Assumes: one clock, async high reset
// Notes: pulse lengths come from helper counters
`timescale 1ns/10ps
`default_nettype none
module wdt_port_chk (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [1:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic INTERVAL_IRQ,
  input wire logic OVERFLOW_OUT_N,
  input wire logic INTERNAL_RESET
);
  logic [9:0] low_cnt;
  logic [9:0] rst_cnt;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  // running length of the current pulses
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      low_cnt <= 10'h000;
      rst_cnt <= 10'h000;
    end else begin
      low_cnt <= OVERFLOW_OUT_N ? 10'h000 : low_cnt + 10'h001;
      rst_cnt <= INTERNAL_RESET ? rst_cnt + 10'h001 : 10'h000;
    end
  end
  sequence ovf_start;
    $fell(OVERFLOW_OUT_N);
  endsequence
  sequence rstc_read;
    REG_RD && REG_ADDR == 2'h3 ##1 !REG_RD;
  endsequence
  sequence ctrl_read;
    REG_RD && REG_ADDR == 2'h0 ##1 !REG_RD;
  endsequence
  chk_ovf_len: assert property ($rose(OVERFLOW_OUT_N) |-> low_cnt inside {10'h082, 10'h085})
    else $error("overflow pulse length wrong");
  chk_rst_len: assert property ($fell(INTERNAL_RESET) |-> rst_cnt == 10'h207)
    else $error("internal reset length wrong");
  chk_rst_with_ovf: assert property ($rose(INTERNAL_RESET) |-> ovf_start)
    else $error("internal reset without overflow output");
  chk_ovf_hold: assert property (ovf_start |=> !OVERFLOW_OUT_N [*8])
    else $error("overflow output too short");
  chk_irq_quiet: assert property (ovf_start |-> !$rose(INTERVAL_IRQ))
    else $error("interval request on watchdog overflow");
  chk_rd_hold: assert property (!REG_RD && !$past(REG_RD) |=> $stable(REG_RDATA))
    else $error("read data moved without a read");
  chk_rstc_fixed: assert property (rstc_read |-> ##1 REG_RDATA[4:0] == 5'h1F)
    else $error("reset control low bits not one");
  chk_ctrl_fixed: assert property (ctrl_read |-> ##1 REG_RDATA[4:3] == 2'h3)
    else $error("control reserved bits not one");
endmodule // wdt_port_chk
bind watchdog_interval_timer_ctrl wdt_port_chk chk_i (.CLOCK(CLOCK), .RESET(RESET),
  .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .INTERVAL_IRQ(INTERVAL_IRQ), .OVERFLOW_OUT_N(OVERFLOW_OUT_N),
  .INTERNAL_RESET(INTERNAL_RESET));
`default_nettype wire
